/* src/rmls_pkg.sv */
// Shared constants of the ring mode and line status register bank
package rmls_pkg;
	// Register indices as numbered in the device map
	localparam logic [7:0] RING_CTRL_IDX = 8'h12;
	localparam logic [7:0] LINE_STAT_IDX = 8'h13;
	// Byte addresses on the bus: four bytes per register index
	localparam logic [9:0] RING_CTRL_ADDR = {RING_CTRL_IDX, 2'b00};
	localparam logic [9:0] LINE_STAT_ADDR = {LINE_STAT_IDX, 2'b00};
	// Field positions
	localparam int RING_SHAPE_BIT = 1;
	localparam int OVERCURRENT_BIT = 0;
	localparam int DROPOUT_BIT = 1;
	localparam int RX_OVERLOAD_LIVE_BIT = 2;
	// Reset values
	localparam logic [7:0] RING_CTRL_RESET = 8'h00;
	localparam logic [7:0] LINE_STAT_RESET = 8'h00;
	// Writable bits of the ring control register
	localparam logic [7:0] RING_CTRL_WMASK = 8'h02;
	// AHB transfer type and response codes
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam logic [1:0] HTRANS_SEQ = 2'h3;
	localparam logic HRESP_OKAY = 1'h0;
	// Clock rate and one-shot timeout
	localparam int unsigned CLK_KHZ = 100000;
	localparam int unsigned ONESHOT_TIME_MS = 5000;
	localparam int unsigned ONESHOT_CYCLES = ONESHOT_TIME_MS * CLK_KHZ;
	localparam int ONESHOT_CNT_W = 29;
	// Ring output selector, {validation enable, shape}
	typedef enum logic [1:0]
	{
		RMLS_RING_HALF = 2'b00,
		RMLS_RING_FULL = 2'b01,
		RMLS_RING_ENVELOPE = 2'b10,
		RMLS_RING_ONESHOT = 2'b11
	} rmls_ring_mode_type;
endpackage

/* src/rmls_status_if.sv */
`timescale 1ns/1ps
`default_nettype none
// Line status flags passed from the flag logic to the register bank
interface rmls_status_if;
	logic rx_overload_live; // Live receive overload, self clearing
	logic rx_overload_latched; // Sticky receive overload
	logic supply_dropout_flag; // No loop current or on-hook while enabled
	logic loop_overcurrent_flag; // Loop current over the selected threshold
	// Producer side
	modport src
	(
		output rx_overload_live,
		output rx_overload_latched,
		output supply_dropout_flag,
		output loop_overcurrent_flag
	);
	// Consumer side
	modport snk
	(
		input rx_overload_live,
		input rx_overload_latched,
		input supply_dropout_flag,
		input loop_overcurrent_flag
	);
endinterface
`default_nettype wire

/* src/rmls_ring_oneshot.sv */
`timescale 1ns/1ps
`default_nettype none
// Unqualified ring one-shot: started by a threshold crossing, ended by timeout
module rmls_ring_oneshot
#(
	parameter int unsigned TIMEOUT_CYCLES = rmls_pkg::ONESHOT_CYCLES
)
(
	// Clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// Trigger and pulse
	input wire logic ring_threshold_cross,
	output logic oneshot_active
);
	// Counter width covers the full five second default
	localparam int CW = rmls_pkg::ONESHOT_CNT_W;
	localparam logic [CW-1:0] LAST = CW'(TIMEOUT_CYCLES - 1);

	// All state of the one-shot
	typedef struct packed
	{
		logic active;
		logic [CW-1:0] cnt;
	} rmls_shot_type;

	rmls_shot_type state_ff; // Registered state
	rmls_shot_type nxt_state; // Next state

	// A crossing restarts the timer so a burst keeps the output high
	always_comb
	begin
		nxt_state = state_ff;
		if (ring_threshold_cross)
		begin
			// Start or restart on a crossing
			nxt_state.active = 1'b1;
			nxt_state.cnt = '0;
		end
		else if (state_ff.active)
		begin
			if (state_ff.cnt == LAST)
			begin
				// Fixed timeout reached
				nxt_state.active = 1'b0;
				nxt_state.cnt = '0;
			end
			else
			begin
				nxt_state.cnt = state_ff.cnt + 1'b1;
			end
		end
	end

	// State register
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			state_ff <= '0;
		end
		else
		begin
			state_ff <= nxt_state;
		end
	end

	assign oneshot_active = state_ff.active;
endmodule
`default_nettype wire

/* src/rmls_line_flags.sv */
`timescale 1ns/1ps
`default_nettype none
// Line status flag logic
module rmls_line_flags
(
	// Clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// Line side conditions
	input wire logic rx_below_ground,
	input wire logic offhook_mask_active,
	input wire logic loop_current_flowing,
	input wire logic device_enabled,
	input wire logic offhook,
	input wire logic overcurrent_160ma,
	input wire logic overcurrent_60ma,
	input wire logic current_limit_select,
	input wire logic rx_overload_clear,
	// Flags out
	rmls_status_if.src flags
);
	// All flag state
	typedef struct packed
	{
		logic overload_live;
		logic overload_latched;
		logic dropout;
		logic overcurrent;
	} rmls_flags_type;

	rmls_flags_type state_ff; // Registered flags
	rmls_flags_type nxt_state; // Next flags
	logic excess; // Excess receive level after off-hook masking

	// Flag evaluation; billing tone enable is deliberately not an input here
	always_comb
	begin
		nxt_state = state_ff;
		excess = rx_below_ground && !offhook_mask_active;
		// Live flag follows the condition and clears by itself
		nxt_state.overload_live = excess;
		// Sticky copy sees the raw pin level, so a masked overload is still recorded;
		// a new overload beats a clear in the same cycle
		if (rx_below_ground)
		begin
			nxt_state.overload_latched = 1'b1;
		end
		else if (rx_overload_clear)
		begin
			nxt_state.overload_latched = 1'b0;
		end
		// Dropout: no loop current, or enabled while on-hook
		nxt_state.dropout = !loop_current_flowing
			|| (device_enabled && !offhook);
		// Overcurrent comparator picked by the limit select
		nxt_state.overcurrent = current_limit_select ? overcurrent_60ma
			: overcurrent_160ma;
	end

	// Flag registers
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			state_ff <= '0;
		end
		else
		begin
			state_ff <= nxt_state;
		end
	end

	assign flags.rx_overload_live = state_ff.overload_live;
	assign flags.rx_overload_latched = state_ff.overload_latched;
	assign flags.supply_dropout_flag = state_ff.dropout;
	assign flags.loop_overcurrent_flag = state_ff.overcurrent;
endmodule
`default_nettype wire

/* src/rmls_ring_mode_line_status_regs.sv */
// Added by the designer: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module rmls_ring_mode_line_status_regs
#(
	parameter int unsigned ONESHOT_CYCLES = rmls_pkg::ONESHOT_CYCLES
)
(
	// Clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	// Ring detector inputs
	input wire logic ring_validation_enable,
	input wire logic ring_halfwave_in,
	input wire logic ring_fullwave_in,
	input wire logic ring_validated_envelope,
	input wire logic ring_threshold_cross,
	// Line condition inputs
	input wire logic rx_below_ground,
	input wire logic offhook_mask_active,
	input wire logic loop_current_flowing,
	input wire logic device_enabled,
	input wire logic offhook,
	input wire logic overcurrent_160ma,
	input wire logic overcurrent_60ma,
	input wire logic current_limit_select,
	input wire logic rx_overload_clear,
	// Outputs to the line side
	output logic ring_detect_output,
	output logic rx_overload_latched
);
	// Register bank state
	typedef struct packed
	{
		logic wr_pend; // Write data phase pending
		logic [9:0] wr_addr; // Captured write address
		logic [7:0] ring_ctrl; // Ring output control register
		logic [31:0] rdata; // Read data for the data phase
		logic ring_out; // Ring detect output
	} rmls_bank_type;

	rmls_bank_type state_ff; // Registered state
	rmls_bank_type nxt_state; // Next state
	rmls_status_if flags_if (); // Flags from the flag logic
	logic oneshot_active; // One-shot pulse
	logic addr_phase; // Valid transfer taken this cycle
	logic [7:0] status_byte; // Assembled line status value
	logic [7:0] ctrl_fwd; // Control value including a write in flight
	rmls_pkg::rmls_ring_mode_type ring_mode; // Current ring output mode

	// Threshold one-shot
	rmls_ring_oneshot #(
		.TIMEOUT_CYCLES(ONESHOT_CYCLES)
	) u_oneshot (
		.hclk(hclk),
		.hresetn(hresetn),
		.ring_threshold_cross(ring_threshold_cross),
		.oneshot_active(oneshot_active)
	);

	// Status flag logic
	rmls_line_flags u_flags (
		.hclk(hclk),
		.hresetn(hresetn),
		.rx_below_ground(rx_below_ground),
		.offhook_mask_active(offhook_mask_active),
		.loop_current_flowing(loop_current_flowing),
		.device_enabled(device_enabled),
		.offhook(offhook),
		.overcurrent_160ma(overcurrent_160ma),
		.overcurrent_60ma(overcurrent_60ma),
		.current_limit_select(current_limit_select),
		.rx_overload_clear(rx_overload_clear),
		.flags(flags_if.src)
	);

	// Status byte, reserved bits read zero
	always_comb
	begin
		status_byte = 8'h00;
		status_byte[rmls_pkg::RX_OVERLOAD_LIVE_BIT] = flags_if.rx_overload_live;
		status_byte[rmls_pkg::DROPOUT_BIT] = flags_if.supply_dropout_flag;
		status_byte[rmls_pkg::OVERCURRENT_BIT] = flags_if.loop_overcurrent_flag;
	end

	// A write in its data phase lands at this edge; forward it so a
	// back-to-back read of the same register sees the new value
	always_comb
	begin
		ctrl_fwd = state_ff.ring_ctrl;
		if (state_ff.wr_pend && state_ff.wr_addr == rmls_pkg::RING_CTRL_ADDR)
		begin
			ctrl_fwd = hwdata[7:0] & rmls_pkg::RING_CTRL_WMASK;
		end
	end

	assign addr_phase = hsel && hready
		&& (htrans == rmls_pkg::HTRANS_NONSEQ || htrans == rmls_pkg::HTRANS_SEQ);
	assign ring_mode = rmls_pkg::rmls_ring_mode_type'({ring_validation_enable,
		state_ff.ring_ctrl[rmls_pkg::RING_SHAPE_BIT]});

	// Bus decode, register update and ring output selection
	always_comb
	begin
		nxt_state = state_ff;
		// Commit the pending write; the status register ignores writes
		if (state_ff.wr_pend)
		begin
			nxt_state.ring_ctrl = ctrl_fwd;
		end
		nxt_state.wr_pend = 1'b0;
		if (addr_phase)
		begin
			if (hwrite)
			begin
				// Data arrives next cycle
				nxt_state.wr_pend = 1'b1;
				nxt_state.wr_addr = haddr[9:0];
			end
			else
			begin
				// Read data registered for the data phase; unmapped reads zero
				case (haddr[9:0])
					rmls_pkg::RING_CTRL_ADDR: nxt_state.rdata = {24'h000000, ctrl_fwd};
					rmls_pkg::LINE_STAT_ADDR: nxt_state.rdata = {24'h000000, status_byte};
					default: nxt_state.rdata = 32'h00000000;
				endcase
			end
		end
		// Ring detect output mode
		case (ring_mode)
			rmls_pkg::RMLS_RING_HALF: nxt_state.ring_out = ring_halfwave_in;
			rmls_pkg::RMLS_RING_FULL: nxt_state.ring_out = ring_fullwave_in;
			rmls_pkg::RMLS_RING_ENVELOPE: nxt_state.ring_out = ring_validated_envelope;
			rmls_pkg::RMLS_RING_ONESHOT: nxt_state.ring_out = oneshot_active;
			default: nxt_state.ring_out = 1'b0;
		endcase
	end

	// State register
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			state_ff.wr_pend <= 1'b0;
			state_ff.wr_addr <= 10'h000;
			state_ff.ring_ctrl <= rmls_pkg::RING_CTRL_RESET;
			state_ff.rdata <= 32'h00000000;
			state_ff.ring_out <= 1'b0;
		end
		else
		begin
			state_ff <= nxt_state;
		end
	end

	// Zero wait state slave, always OKAY
	assign hreadyout = 1'b1;
	assign hresp = rmls_pkg::HRESP_OKAY;
	assign hrdata = state_ff.rdata;
	assign ring_detect_output = state_ff.ring_out;
	assign rx_overload_latched = flags_if.rx_overload_latched;
endmodule
`default_nettype wire

/* sim/rmls_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
// Ring output selection and status read checks at the top ports
module rmls_assertions
#(
	parameter int unsigned ONESHOT_CYCLES = 20
)
(
	// Clock, reset
	input wire logic hclk,
	input wire logic hresetn,
	// Bus
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	input wire logic [31:0] hrdata,
	// Line side
	input wire logic ring_validation_enable,
	input wire logic ring_halfwave_in,
	input wire logic ring_fullwave_in,
	input wire logic ring_validated_envelope,
	input wire logic ring_threshold_cross,
	input wire logic rx_below_ground,
	input wire logic offhook_mask_active,
	input wire logic loop_current_flowing,
	input wire logic device_enabled,
	input wire logic offhook,
	input wire logic overcurrent_160ma,
	input wire logic overcurrent_60ma,
	input wire logic current_limit_select,
	input wire logic ring_detect_output,
	input wire logic rx_overload_latched,
	input wire logic rx_overload_clear
);
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	logic wp_ff, sh_ff; // Shape write in data phase, shadow shape bit
	logic [31:0] q_ff; // Cycles since last crossing, saturates so no false wrap
	wire logic rv = ring_validation_enable;
	wire logic hit = hsel && hready && htrans[1]; // Transfer taken this cycle
	wire logic rs = hit && !hwrite && haddr[9:0] == rmls_pkg::LINE_STAT_ADDR;
	// Shadow of the control register and crossing age
	always_ff @(posedge hclk or negedge hresetn)
		if (!hresetn)
			{wp_ff, sh_ff, q_ff} <= {2'h0, 32'hFFFF_FFFF};
		else
		begin
			wp_ff <= hit && hwrite && haddr[9:0] == rmls_pkg::RING_CTRL_ADDR;
			sh_ff <= wp_ff ? hwdata[1] : sh_ff;
			q_ff <= ring_threshold_cross ? 32'h0 : q_ff + {31'h0, ~&q_ff};
		end
	// The edge after a reset release still shows the reset output, so the
	// previous cycle must have been out of reset
	a_half_wave: assert property ($past(hresetn && !rv && !sh_ff)
		|-> ring_detect_output == $past(ring_halfwave_in))
		else $error("half wave output wrong");
	a_full_wave: assert property ($past(hresetn && !rv && sh_ff)
		|-> ring_detect_output == $past(ring_fullwave_in))
		else $error("full wave output wrong");
	a_ring_envelope: assert property ($past(hresetn && rv && !sh_ff)
		|-> ring_detect_output == $past(ring_validated_envelope))
		else $error("envelope output wrong");
	a_oneshot_held: assert property ($past(hresetn && rv && sh_ff)
		&& q_ff >= 2 && q_ff < ONESHOT_CYCLES |-> ring_detect_output)
		else $error("one-shot dropped early");
	a_oneshot_ends: assert property ($past(hresetn && rv && sh_ff)
		&& q_ff > ONESHOT_CYCLES |-> !ring_detect_output)
		else $error("one-shot held past timeout");
	a_live_overload: assert property ($past(rs)
		|-> hrdata[2] == $past(rx_below_ground && !offhook_mask_active, 2))
		else $error("live overload bit wrong");
	a_supply_dropout: assert property ($past(rs)
		|-> hrdata[1] == $past(!loop_current_flowing || (device_enabled && !offhook), 2))
		else $error("dropout bit wrong");
	a_loop_overcurrent: assert property ($past(rs)
		|-> hrdata[0] == $past(current_limit_select ? overcurrent_60ma : overcurrent_160ma, 2))
		else $error("overcurrent bit wrong");
	a_latch_set: assert property (rx_below_ground |=> rx_overload_latched)
		else $error("sticky overload not set");
	a_latch_clear: assert property (!rx_below_ground && rx_overload_clear
		|=> !rx_overload_latched)
		else $error("sticky overload not cleared");
endmodule
bind rmls_ring_mode_line_status_regs rmls_assertions
	#(.ONESHOT_CYCLES(ONESHOT_CYCLES)) rmls_assertions_inst (.*);
`default_nettype wire

/* sim/rmls_bus_master.sv */
`timescale 1ns/1ps
`default_nettype none
// System-side bus master: single word transfers, waits for hready
module rmls_bus_master
(
	// Clock
	input wire logic hclk,
	// Request
	output logic hsel,
	output logic [31:0] haddr,
	output logic [1:0] htrans,
	output logic hwrite,
	output logic [2:0] hsize,
	output logic [31:0] hwdata,
	// Answer
	input wire logic hready,
	input wire logic [31:0] hrdata
);
	logic hung = 1'b0; // A wait ran out
	initial {hsel, haddr, htrans, hwrite, hsize, hwdata} = '0;
	// Bounded wait for hready at a rising edge
	task automatic wait_ready();
		int n;
		@(posedge hclk);
		for (n = 0; hready !== 1'b1 && n < 50; n++)
			@(posedge hclk);
		if (n == 50)
			hung = 1'b1;
	endtask
	// Released lines show inverted data so stale values never match
	task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d, output logic [31:0] r);
		hsel <= 1'b1;
		haddr <= a;
		hwrite <= w;
		hsize <= 3'h2;
		htrans <= rmls_pkg::HTRANS_NONSEQ;
		hwdata <= ~hwdata;
		wait_ready();
		hsel <= 1'b0;
		haddr <= ~a;
		htrans <= 2'h0;
		hwdata <= d;
		wait_ready();
		r = hrdata;
	endtask
endmodule
`default_nettype wire

/* sim/rmls_ring_mode_line_status_regs_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module rmls_ring_mode_line_status_regs_tb;
	localparam int unsigned N = 20; // Short one-shot keeps the run brief
	localparam logic [31:0] RC = {22'h0, rmls_pkg::RING_CTRL_ADDR};
	localparam logic [31:0] LS = {22'h0, rmls_pkg::LINE_STAT_ADDR};
	logic hclk = 1'b0, hresetn = 1'b0, hsel, hwrite, hready, hreadyout, hresp;
	logic [31:0] haddr, hwdata, hrdata, r, q, seed = 32'h8B10;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic ring_validation_enable = 1'b0, ring_halfwave_in = 1'b0, ring_fullwave_in = 1'b0;
	logic ring_validated_envelope = 1'b0, ring_threshold_cross = 1'b0, rx_below_ground = 1'b0;
	logic offhook_mask_active = 1'b0, loop_current_flowing = 1'b1, device_enabled = 1'b0;
	logic offhook = 1'b0, overcurrent_160ma = 1'b0, overcurrent_60ma = 1'b0;
	logic current_limit_select = 1'b0, rx_overload_clear = 1'b0, ring_detect_output;
	logic rx_overload_latched, lat = 1'b0;
	int fail_count = 0, compares = 0, n;
	always #5 hclk = ~hclk;
	assign hready = hreadyout;
	rmls_ring_mode_line_status_regs #(.ONESHOT_CYCLES(N)) rmls_ring_mode_line_status_regs_inst (.*);
	rmls_bus_master rmls_bus_master_inst (.*);
	// Xorshift source
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	// Status word expected from the line inputs
	function automatic logic [31:0] exp_stat();
		return {29'h0, rx_below_ground & ~offhook_mask_active,
			~loop_current_flowing | (device_enabled & ~offhook),
			current_limit_select ? overcurrent_60ma : overcurrent_160ma};
	endfunction
	// Ring output expected; an idle one-shot reads low
	function automatic logic exp_ring(input logic sh);
		return ring_validation_enable ? (sh ? 1'b0 : ring_validated_envelope)
			: (sh ? ring_fullwave_in : ring_halfwave_in);
	endfunction
	task automatic stop_test();
		if (fail_count == 0 && compares > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp)
		begin
			fail_count++;
			$display("CHECK FAILED %0t got %h want %h", $time, got, exp);
		end
	endtask
	// One bus transfer; a hung bus ends the run
	task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
		rmls_bus_master_inst.xfer(w, a, d, q);
		chk({31'h0, hresp}, {31'h0, rmls_pkg::HRESP_OKAY});
		if (rmls_bus_master_inst.hung)
		begin
			fail_count++;
			stop_test();
		end
	endtask
	initial
	begin
		repeat (20) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		bus(0, RC, 0);
		chk(q, 0);
		bus(0, LS, 0);
		chk(q, 0);
		bus(1, RC, 32'hFFFF_FFFF);
		bus(0, RC, 0);
		chk(q, 32'h2);
		bus(1, LS, 32'hFFFF_FFFF);
		bus(0, LS, 0);
		chk(q, 0);
		bus(0, 32'h50, 0);
		chk(q, 0);
		repeat (60)
		begin
			@(posedge hclk);
			r = rnd();
			{ring_validation_enable, ring_halfwave_in, ring_fullwave_in, ring_validated_envelope,
				rx_below_ground, offhook_mask_active, loop_current_flowing, device_enabled,
				offhook, overcurrent_160ma, overcurrent_60ma, current_limit_select,
				rx_overload_clear} <= r[14:2];
			bus(1, RC, r);
			bus(0, LS, 0);
			#1;
			chk(q, exp_stat());
			chk({31'h0, ring_detect_output}, {31'h0, exp_ring(r[1])});
			lat = rx_below_ground | (~rx_overload_clear & lat);
			chk({31'h0, rx_overload_latched}, {31'h0, lat});
		end
		@(posedge hclk);
		ring_validation_enable <= 1'b1;
		bus(1, RC, 32'h2);
		ring_threshold_cross <= 1'b1;
		@(posedge hclk);
		ring_threshold_cross <= 1'b0;
		n = 0;
		repeat (N + 10)
		begin
			@(posedge hclk);
			#1;
			if (ring_detect_output === 1'b1)
				n++;
		end
		chk(32'(n), N);
		@(posedge hclk);
		hresetn <= 1'b0;
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		bus(0, RC, 0);
		chk(q, 0);
		stop_test();
	end
endmodule
`default_nettype wire
